// *** include/core_regs_defs.vh ***
// constants for the core register file and interrupt entry block
`ifndef CORE_REGS_DEFS_VH
`define CORE_REGS_DEFS_VH

// ==========================================================
// memory-mapped offsets
`define IDX_HIGH_OFF   8'hbe
`define IDX_LOW_OFF    8'hbf
`define SP_OFF         8'hce
`define FLAGS_OFF      8'hcf

// ==========================================================
// condition_flags bit positions
`define FLAG_C         0
`define FLAG_H         1
`define FLAG_Z         2
`define FLAG_N         3
`define FLAG_G         4
`define FLAG_R         5

// ==========================================================
// reset values and fixed addresses
`define SP_RESET       4'hf
`define STACK_BASE     8'h30
`define PC_BASE        12'h800
`define PC_RESET_OFS   10'h000
`define IDX_SPACE_BIT  11

`endif

// *** hdl/irq_priority.v ***
// fixed-priority selector for the four interrupt sources
`timescale 1ns/1ns
module irq_priority (
  // requests: [3] wake-up edge, [2] first timer, [1] second timer, [0] software
  input  wire [3:0] req_i,
  // selection
  output reg  [3:0] grant_o,
  output wire       any_o
);

  assign any_o = |req_i;

  // ==========================================================
  // highest set request wins
  always @* begin
    grant_o = 4'h0;
    if (req_i[3]) begin
      grant_o = 4'h8;
    end else if (req_i[2]) begin
      grant_o = 4'h4;
    end else if (req_i[1]) begin
      grant_o = 4'h2;
    end else if (req_i[0]) begin
      grant_o = 4'h1;
    end
  end

endmodule

// *** hdl/core_regs.v ***
// programmer-visible core registers, stack sequencing and interrupt entry
//
// Behaviour
// - an 8-bit accumulator holds operands and results.
// - indexed address is index bits 10:0 plus an 8-bit offset, cut to 8 bits in data space.
// - indexed writes into program space never reach code memory.
// - index pointer high nibble at 0xBE, low byte at 0xBF.
// - index bit 11 is write-only; 0 selects data, 1 program space.
// - only the lower eleven index bits count; bit 11 never changes by counting.
// - 10-bit program counter, reset to address 0x800 in normal mode.
// - 4-bit stack pointer over 0x30-0x3F, reset to 0xF.
// - push decrements by two, pull increments by two, points at free slot.
// - call pushes return address low byte first; return pulls it into PC.
// - 8-bit flags register with C, H, Z, N, mask G and write-busy R.
// - carry from ALU, set/clear, rotate, carry-load and carry-invert ops.
// - half carry records the nibble boundary overflow.
// - zero flag set when the result is zero, else cleared.
// - negative flag copies result bit seven.
// - mask clear keeps interrupts pending; mask set lets them be recognized.
// - mask clear after reset; set by the mask-set instruction, interrupt return or a flags write.
// - interrupt entry pushes PC, fetches vector, clears mask; five cycles.
// - interrupt return pulls in reverse order, sets mask, resumes there.
// - priority wake-up edge, first timer, second timer, software.
`timescale 1ns/1ns
`include "core_regs_defs.vh"
module core_regs #(
  parameter PC_W        = 10,
  parameter TEST_PC_OFS = 10'h000,
  parameter VEC_EDGE    = 12'hbfa,
  parameter VEC_TMR0    = 12'hbfb,
  parameter VEC_TMR1    = 12'hbfc,
  parameter VEC_SWI     = 12'hbfd
) (
  // clock and reset
  input  wire             sys_clk_i,
  input  wire             sys_rst_i,
  input  wire             normal_mode_i,
  // accumulator
  input  wire             acc_we_i,
  input  wire [7:0]       acc_d_i,
  output reg  [7:0]       acc_o,
  // flag updates from the execution unit
  input  wire [3:0]       flag_we_i,
  input  wire [7:0]       alu_result_i,
  input  wire             alu_carry_i,
  input  wire             alu_half_i,
  input  wire             carry_load_op_i,
  input  wire             carry_load_bit_i,
  input  wire             carry_invert_op_i,
  input  wire             mask_set_i,
  input  wire             mask_clear_i,
  input  wire             eeprom_busy_i,
  output wire [7:0]       condition_flags_o,
  // index pointer
  input  wire             idx_load_i,
  input  wire [11:0]      idx_d_i,
  input  wire             idx_inc_i,
  input  wire             idx_dec_i,
  input  wire             idx_req_i,
  input  wire             idx_wr_i,
  input  wire [7:0]       idx_offset_i,
  output reg  [11:0]      eff_addr_o,
  output reg              idx_mem_re_o,
  output reg              idx_mem_we_o,
  // program counter
  input  wire             pc_load_i,
  input  wire [11:0]      pc_d_i,
  input  wire             pc_inc_i,
  output wire [11:0]      pc_o,
  // call, return and interrupt sequencing
  input  wire             subroutine_call_i,
  input  wire [11:0]      call_target_i,
  input  wire             subroutine_return_i,
  input  wire             interrupt_return_i,
  input  wire             instr_done_i,
  input  wire             wakeup_edge_irq_i,
  input  wire             first_timer_irq_i,
  input  wire             second_timer_irq_i,
  input  wire             software_interrupt_i,
  output reg  [3:0]       irq_ack_o,
  output wire             seq_busy_o,
  // stack memory port
  output reg  [7:0]       stack_addr_o,
  output reg  [7:0]       stack_wdata_o,
  output reg              stack_we_o,
  output reg              stack_re_o,
  input  wire [7:0]       stack_rdata_i,
  // memory-mapped access
  input  wire [7:0]       mem_addr_i,
  input  wire             mem_wr_i,
  input  wire             mem_rd_i,
  input  wire [7:0]       mem_wdata_i,
  output reg  [7:0]       mem_rdata_o,
  output reg              mem_hit_o
);

  // ==========================================================
  // sequencer states
  localparam [2:0] S_IDLE    = 3'd0;
  localparam [2:0] S_PUSH_LO = 3'd1;
  localparam [2:0] S_PUSH_HI = 3'd2;
  localparam [2:0] S_VECTOR  = 3'd3;
  localparam [2:0] S_PULL_HI = 3'd4;
  localparam [2:0] S_PULL_LO = 3'd5;
  localparam [2:0] S_FINISH  = 3'd6;

  reg [2:0]       state;
  reg [3:0]       sp;
  reg [11:0]      idx;
  reg [PC_W-1:0]  pc;
  reg             flag_c;
  reg             flag_h;
  reg             flag_z;
  reg             flag_n;
  reg             flag_g;
  reg             is_irq;
  reg             is_interrupt_return;
  reg [11:0]      seq_target;
  reg [11:0]      ret_addr;
  reg [3:0]       grant_q;
  reg             ret_addr_pending;
  wire [3:0]      grant;
  wire            irq_any;
  wire            recognize;
  wire            call_start;
  wire            ret_start;
  wire [10:0]     idx_sum;

  // ==========================================================
  // helpers
  function [7:0] stack_addr;
    input [3:0] ptr;
    begin
      stack_addr = `STACK_BASE + {4'h0, ptr};
    end
  endfunction

  function [PC_W-1:0] to_pc;
    input [11:0] addr;
    reg   [11:0] ofs;
    begin
      ofs   = addr - `PC_BASE;
      to_pc = ofs[PC_W-1:0];
    end
  endfunction

  // ==========================================================
  // interrupt arbitration
  irq_priority u_prio (
    .req_i   ({wakeup_edge_irq_i, first_timer_irq_i, second_timer_irq_i, software_interrupt_i}),
    .grant_o (grant),
    .any_o   (irq_any)
  );

  assign call_start = (state == S_IDLE) && subroutine_call_i;
  assign ret_start  = (state == S_IDLE) && !subroutine_call_i && (subroutine_return_i || interrupt_return_i);
  assign recognize  = (state == S_IDLE) && flag_g && irq_any && instr_done_i &&
                      !subroutine_call_i && !subroutine_return_i && !interrupt_return_i;
  assign seq_busy_o = (state != S_IDLE);
  assign pc_o       = `PC_BASE + {{(12-PC_W){1'b0}}, pc};

  // ==========================================================
  // accumulator
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      acc_o <= 8'h00;
    end else if (acc_we_i) begin
      acc_o <= acc_d_i;
    end
  end

  // ==========================================================
  // index pointer and indexed address
  assign idx_sum = idx[10:0] + {3'h0, idx_offset_i};

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      idx <= 12'h000;
    end else if (idx_load_i) begin
      idx <= idx_d_i;
    end else if (idx_inc_i) begin
      idx[10:0] <= idx[10:0] + 11'h001;
    end else if (idx_dec_i) begin
      idx[10:0] <= idx[10:0] - 11'h001;
    end else if (mem_wr_i && mem_addr_i == `IDX_HIGH_OFF) begin
      idx[11:8] <= mem_wdata_i[3:0];
    end else if (mem_wr_i && mem_addr_i == `IDX_LOW_OFF) begin
      idx[7:0] <= mem_wdata_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      eff_addr_o   <= 12'h000;
      idx_mem_re_o <= 1'b0;
      idx_mem_we_o <= 1'b0;
    end else begin
      idx_mem_re_o <= idx_req_i && !idx_wr_i;
      idx_mem_we_o <= idx_req_i && idx_wr_i && !idx[`IDX_SPACE_BIT];
      if (idx_req_i) begin
        if (idx[`IDX_SPACE_BIT]) begin
          eff_addr_o <= {1'b1, idx_sum};
        end else begin
          eff_addr_o <= {4'h0, idx_sum[7:0]};
        end
      end
    end
  end

  // ==========================================================
  // condition flags
  assign condition_flags_o = {2'b00, eeprom_busy_i, flag_g, flag_n, flag_z, flag_h, flag_c};

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      flag_c <= 1'b0;
      flag_h <= 1'b0;
      flag_z <= 1'b0;
      flag_n <= 1'b0;
    end else begin
      if (flag_we_i[`FLAG_C]) begin
        flag_c <= alu_carry_i;
      end else if (carry_load_op_i) begin
        flag_c <= carry_load_bit_i;
      end else if (carry_invert_op_i) begin
        flag_c <= !flag_c;
      end else if (mem_wr_i && mem_addr_i == `FLAGS_OFF) begin
        flag_c <= mem_wdata_i[`FLAG_C];
      end
      if (flag_we_i[`FLAG_H]) begin
        flag_h <= alu_half_i;
      end else if (mem_wr_i && mem_addr_i == `FLAGS_OFF) begin
        flag_h <= mem_wdata_i[`FLAG_H];
      end
      if (flag_we_i[`FLAG_Z]) begin
        flag_z <= (alu_result_i == 8'h00);
      end else if (mem_wr_i && mem_addr_i == `FLAGS_OFF) begin
        flag_z <= mem_wdata_i[`FLAG_Z];
      end
      if (flag_we_i[`FLAG_N]) begin
        flag_n <= alu_result_i[7];
      end else if (mem_wr_i && mem_addr_i == `FLAGS_OFF) begin
        flag_n <= mem_wdata_i[`FLAG_N];
      end
    end
  end

  // mask: hardware entry clear and return set take precedence over software
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      flag_g <= 1'b0;
    end else if (state == S_FINISH && is_irq) begin
      flag_g <= 1'b0;
    end else if (state == S_FINISH && is_interrupt_return) begin
      flag_g <= 1'b1;
    end else if (mask_set_i) begin
      flag_g <= 1'b1;
    end else if (mask_clear_i) begin
      flag_g <= 1'b0;
    end else if (mem_wr_i && mem_addr_i == `FLAGS_OFF) begin
      flag_g <= mem_wdata_i[`FLAG_G];
    end
  end

  // ==========================================================
  // call, return and interrupt entry sequencer
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state         <= S_IDLE;
      sp            <= `SP_RESET;
      pc            <= normal_mode_i ? `PC_RESET_OFS : TEST_PC_OFS;
      is_irq        <= 1'b0;
      is_interrupt_return       <= 1'b0;
      seq_target    <= 12'h000;
      ret_addr      <= 12'h000;
      grant_q       <= 4'h0;
      irq_ack_o     <= 4'h0;
      stack_addr_o  <= 8'h00;
      stack_wdata_o <= 8'h00;
      stack_we_o    <= 1'b0;
      stack_re_o    <= 1'b0;
    end else begin
      stack_we_o <= 1'b0;
      stack_re_o <= 1'b0;
      irq_ack_o  <= 4'h0;
      case (state)
        S_IDLE: begin
          if (call_start || recognize) begin
            state         <= S_PUSH_LO;
            is_irq        <= recognize;
            is_interrupt_return       <= 1'b0;
            grant_q       <= grant;
            seq_target    <= call_target_i;
            stack_addr_o  <= stack_addr(sp);
            stack_wdata_o <= pc_o[7:0];
            stack_we_o    <= 1'b1;
          end else if (ret_start) begin
            state        <= S_PULL_HI;
            is_irq       <= 1'b0;
            is_interrupt_return      <= interrupt_return_i;
            stack_addr_o <= stack_addr(sp + 4'h1);
            stack_re_o   <= 1'b1;
          end else if (pc_load_i) begin
            pc <= to_pc(pc_d_i);
          end else if (pc_inc_i) begin
            pc <= pc + {{(PC_W-1){1'b0}}, 1'b1};
          end else if (mem_wr_i && mem_addr_i == `SP_OFF) begin
            sp <= mem_wdata_i[3:0];
          end
        end
        S_PUSH_LO: begin
          state         <= S_PUSH_HI;
          stack_addr_o  <= stack_addr(sp - 4'h1);
          stack_wdata_o <= {4'h0, pc_o[11:8]};
          stack_we_o    <= 1'b1;
          sp            <= sp - 4'h2;
        end
        S_PUSH_HI: begin
          state <= is_irq ? S_VECTOR : S_FINISH;
        end
        S_VECTOR: begin
          state     <= S_FINISH;
          irq_ack_o <= grant_q;
          if (grant_q[3]) begin
            seq_target <= VEC_EDGE;
          end else if (grant_q[2]) begin
            seq_target <= VEC_TMR0;
          end else if (grant_q[1]) begin
            seq_target <= VEC_TMR1;
          end else begin
            seq_target <= VEC_SWI;
          end
        end
        S_PULL_HI: begin
          state        <= S_PULL_LO;
          stack_addr_o <= stack_addr(sp + 4'h2);
          stack_re_o   <= 1'b1;
        end
        S_PULL_LO: begin
          state          <= S_FINISH;
          ret_addr[11:8] <= stack_rdata_i[3:0];
          sp             <= sp + 4'h2;
        end
        S_FINISH: begin
          state <= S_IDLE;
          if (is_irq || !(is_interrupt_return || ret_addr_pending)) begin
            pc <= to_pc(seq_target);
          end else begin
            pc <= to_pc({ret_addr[11:8], stack_rdata_i});
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // marks that the finishing sequence is a pull rather than a call
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ret_addr_pending <= 1'b0;
    end else if (ret_start) begin
      ret_addr_pending <= 1'b1;
    end else if (state == S_FINISH) begin
      ret_addr_pending <= 1'b0;
    end
  end

  // ==========================================================
  // memory-mapped read port
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mem_rdata_o <= 8'h00;
      mem_hit_o   <= 1'b0;
    end else begin
      mem_hit_o   <= 1'b0;
      mem_rdata_o <= 8'h00;
      if (mem_rd_i) begin
        if (mem_addr_i == `IDX_HIGH_OFF) begin
          mem_rdata_o <= {5'h00, idx[10:8]};
          mem_hit_o   <= 1'b1;
        end else if (mem_addr_i == `IDX_LOW_OFF) begin
          mem_rdata_o <= idx[7:0];
          mem_hit_o   <= 1'b1;
        end else if (mem_addr_i == `SP_OFF) begin
          mem_rdata_o <= {4'h0, sp};
          mem_hit_o   <= 1'b1;
        end else if (mem_addr_i == `FLAGS_OFF) begin
          mem_rdata_o <= condition_flags_o;
          mem_hit_o   <= 1'b1;
        end
      end
    end
  end

endmodule

// *** tb/core_regs_monitor.sv ***
// concurrent checks on the ports of the core register block
`timescale 1ns/1ns
module core_regs_monitor (
  // clock and reset
  input wire        sys_clk_i,
  input wire        sys_rst_i,
  input wire        normal_mode_i,
  // flags and pointers
  input wire [3:0]  flag_we_i,
  input wire [7:0]  alu_result_i,
  input wire [7:0]  condition_flags_o,
  input wire [11:0] eff_addr_o,
  input wire        idx_mem_we_o,
  input wire [11:0] pc_o,
  // sequencing
  input wire        subroutine_call_i,
  input wire        interrupt_return_i,
  input wire [3:0]  irq_ack_o,
  input wire        seq_busy_o,
  input wire [7:0]  stack_addr_o,
  input wire [7:0]  stack_wdata_o,
  input wire        stack_we_o,
  input wire        stack_re_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // assertions
  stack_window_a: assert property ((stack_we_o || stack_re_o) |-> stack_addr_o[7:4] == 4'h3)
    else $error("stack access outside stack window");
  call_low_a: assert property (subroutine_call_i && !seq_busy_o |=> stack_we_o && stack_wdata_o == $past(pc_o[7:0]))
    else $error("call did not push low byte first");
  call_high_a: assert property (subroutine_call_i && !seq_busy_o |=> stack_we_o ##1
    (stack_we_o && stack_addr_o == $past(stack_addr_o) - 8'h01))
    else $error("second push not one below first");
  ack_gated_a: assert property (irq_ack_o != 4'h0 |-> $past(condition_flags_o[4], 4) && $onehot(irq_ack_o))
    else $error("interrupt served while mask clear");
  entry_len_a: assert property (irq_ack_o != 4'h0 |-> seq_busy_o ##1 (!seq_busy_o && !condition_flags_o[4]))
    else $error("interrupt entry length or mask wrong");
  iret_mask_a: assert property (interrupt_return_i && !seq_busy_o |-> ##4 condition_flags_o[4])
    else $error("interrupt return did not set mask");
  reset_state_a: assert property ($fell(sys_rst_i) |-> !condition_flags_o[4] && (!normal_mode_i || pc_o == 12'h800))
    else $error("mask or counter wrong after reset");
  prog_ro_a: assert property (idx_mem_we_o |-> !eff_addr_o[11])
    else $error("indexed write into program space");
  zero_flag_a: assert property (flag_we_i[2] |=> condition_flags_o[2] == ($past(alu_result_i) == 8'h00))
    else $error("zero flag wrong");
  neg_flag_a: assert property (flag_we_i[3] |=> condition_flags_o[3] == $past(alu_result_i[7]))
    else $error("negative flag wrong");
  // ==========================================================
  // coverage
  cover property (irq_ack_o[3]);
  cover property (stack_re_o);
  cover property (idx_mem_we_o);
  cover property (subroutine_call_i && !seq_busy_o);
endmodule
bind core_regs core_regs_monitor core_regs_monitor_inst (.*);

// *** tb/stack_ram_model.sv ***
// stack memory seen by the core register block
`timescale 1ns/1ns
module stack_ram_model (
  // memory port
  input  wire logic       clk_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] rdata_o
);
  logic [7:0] mem [16];
  initial rdata_o = 8'h00;
  // read data valid one cycle after the strobe, otherwise a toggling pattern
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i[3:0]] <= wdata_i;
    end
    rdata_o <= re_i ? mem[addr_i[3:0]] : ~rdata_o;
  end
endmodule

// *** tb/tb_top.sv ***
// self-checking testbench for the core register block
`timescale 1ns/1ns
module tb_top;
  // ==========================================================
  // signals
  logic sys_clk_i = 1'h0, sys_rst_i = 1'h1, normal_mode_i = 1'h1, instr_done_i = 1'h1;
  logic acc_we_i = 1'h0, alu_carry_i = 1'h0, alu_half_i = 1'h0, carry_load_op_i = 1'h0, carry_load_bit_i = 1'h0;
  logic carry_invert_op_i = 1'h0, mask_set_i = 1'h0, mask_clear_i = 1'h0, eeprom_busy_i = 1'h0, idx_load_i = 1'h0;
  logic idx_inc_i = 1'h0, idx_dec_i = 1'h0, idx_req_i = 1'h0, idx_wr_i = 1'h0, pc_load_i = 1'h0, pc_inc_i = 1'h0;
  logic subroutine_call_i = 1'h0, subroutine_return_i = 1'h0, interrupt_return_i = 1'h0, mem_wr_i = 1'h0;
  logic mem_rd_i = 1'h0;
  logic [3:0]  flag_we_i = 4'h0, irq = 4'h0;
  logic [7:0]  acc_d_i = 8'h00, alu_result_i = 8'h00, idx_offset_i = 8'h00, mem_addr_i = 8'h00, mem_wdata_i = 8'h00;
  logic [11:0] idx_d_i = 12'h000, pc_d_i = 12'h000, call_target_i = 12'h000;
  wire         wakeup_edge_irq_i = irq[3], first_timer_irq_i = irq[2];
  wire         second_timer_irq_i = irq[1], software_interrupt_i = irq[0];
  wire [7:0]   acc_o, condition_flags_o, stack_addr_o, stack_wdata_o, stack_rdata_i, mem_rdata_o;
  wire [11:0]  eff_addr_o, pc_o;
  wire [3:0]   irq_ack_o;
  wire         idx_mem_re_o, idx_mem_we_o, seq_busy_o, stack_we_o, stack_re_o, mem_hit_o;
  int          n_fail = 0, tests_run = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  core_regs #(.TEST_PC_OFS(10'h040)) core_regs_inst (.*);
  stack_ram_model stack_ram_model_inst (.clk_i(sys_clk_i), .we_i(stack_we_o), .re_i(stack_re_o),
    .addr_i(stack_addr_o), .wdata_i(stack_wdata_o), .rdata_o(stack_rdata_i));
  // ==========================================================
  // shared tasks
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic mem_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    mem_wr_i <= 1'h1;
    mem_addr_i <= a;
    mem_wdata_i <= d;
    @(posedge sys_clk_i);
    mem_wr_i <= 1'h0;
  endtask
  task automatic mem_rd(input logic [7:0] a, output logic [8:0] d);
    @(posedge sys_clk_i);
    mem_rd_i <= 1'h1;
    mem_addr_i <= a;
    @(posedge sys_clk_i);
    mem_rd_i <= 1'h0;
    #1 d = {mem_hit_o, mem_rdata_o};
  endtask
  task automatic wait_for(input logic ack);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      #1 n++;
    end while ((ack ? irq_ack_o == 4'h0 : seq_busy_o !== 1'h0) && n < 20);
    if (n >= 20) begin
      n_fail++;
      final_report();
    end
  endtask
  task automatic idx_acc(input logic [7:0] off, input logic wr, input logic [11:0] ea, input logic [1:0] rw);
    @(posedge sys_clk_i);
    idx_req_i <= 1'h1;
    idx_wr_i <= wr;
    idx_offset_i <= off;
    @(posedge sys_clk_i);
    idx_req_i <= 1'h0;
    #1 chk(eff_addr_o, ea);
    chk({idx_mem_re_o, idx_mem_we_o}, rw);
  endtask
  // ==========================================================
  // scenarios
  task automatic s_reset;
    logic [8:0] d;
    chk(condition_flags_o, 12'h000);
    chk(pc_o, 12'h800);
    mem_rd(8'hce, d);
    chk(d, 12'h10f);
    mem_rd(8'hc5, d);
    chk(d, 12'h000);
  endtask
  task automatic s_flags;
    @(posedge sys_clk_i);
    {acc_we_i, acc_d_i, alu_result_i, flag_we_i, eeprom_busy_i} <= {1'h1, 8'ha5, 8'h00, 4'hc, 1'h1};
    @(posedge sys_clk_i);
    {acc_we_i, alu_result_i} <= {1'h0, 8'h80};
    #1 chk(acc_o, 12'h0a5);
    chk(condition_flags_o, 12'h024);
    @(posedge sys_clk_i);
    {flag_we_i, alu_carry_i, alu_half_i} <= {4'h3, 1'h1, 1'h1};
    #1 chk(condition_flags_o, 12'h028);
    @(posedge sys_clk_i);
    {flag_we_i, carry_invert_op_i} <= {4'h0, 1'h1};
    #1 chk(condition_flags_o, 12'h02b);
    @(posedge sys_clk_i);
    {carry_invert_op_i, carry_load_op_i, carry_load_bit_i} <= {1'h0, 1'h1, 1'h1};
    #1 chk(condition_flags_o, 12'h02a);
    @(posedge sys_clk_i);
    carry_load_op_i <= 1'h0;
    #1 chk(condition_flags_o, 12'h02b);
    @(posedge sys_clk_i);
    eeprom_busy_i <= 1'h0;
    #1 chk(condition_flags_o, 12'h00b);
  endtask
  task automatic s_index;
    logic [8:0] d;
    mem_wr(8'hbe, 8'hff);
    mem_wr(8'hbf, 8'hff);
    mem_rd(8'hbe, d);
    chk(d, 12'h107);
    @(posedge sys_clk_i);
    idx_inc_i <= 1'h1;
    @(posedge sys_clk_i);
    idx_inc_i <= 1'h0;
    idx_acc(8'h05, 1'h0, 12'h805, 2'h2);
    idx_acc(8'h05, 1'h1, 12'h805, 2'h0);
    mem_rd(8'hbf, d);
    chk(d, 12'h100);
    @(posedge sys_clk_i);
    {idx_load_i, idx_d_i} <= {1'h1, 12'h0f0};
    @(posedge sys_clk_i);
    {idx_load_i, idx_dec_i} <= {1'h0, 1'h1};
    @(posedge sys_clk_i);
    idx_dec_i <= 1'h0;
    idx_acc(8'h20, 1'h1, 12'h00f, 2'h1);
  endtask
  task automatic s_call;
    logic [8:0] d;
    @(posedge sys_clk_i);
    {pc_load_i, pc_d_i} <= {1'h1, 12'h8a2};
    @(posedge sys_clk_i);
    {pc_load_i, pc_inc_i} <= {1'h0, 1'h1};
    @(posedge sys_clk_i);
    {pc_inc_i, subroutine_call_i, call_target_i} <= {1'h0, 1'h1, 12'h9c4};
    @(posedge sys_clk_i);
    subroutine_call_i <= 1'h0;
    wait_for(1'h0);
    chk(pc_o, 12'h9c4);
    chk(stack_ram_model_inst.mem[15], 12'h0a3);
    chk(stack_ram_model_inst.mem[14], 12'h008);
    mem_rd(8'hce, d);
    chk(d, 12'h10d);
    @(posedge sys_clk_i);
    subroutine_return_i <= 1'h1;
    @(posedge sys_clk_i);
    subroutine_return_i <= 1'h0;
    wait_for(1'h0);
    chk(pc_o, 12'h8a3);
    mem_rd(8'hce, d);
    chk(d, 12'h10f);
  endtask
  task automatic s_irq;
    logic [11:0] vec [4];
    vec = '{12'hbfd, 12'hbfc, 12'hbfb, 12'hbfa};
    @(posedge sys_clk_i);
    irq <= 4'h4;
    repeat (6) @(posedge sys_clk_i);
    #1 chk({seq_busy_o, pc_o[10:0]}, 12'h0a3);
    for (int i = 3; i >= 0; i--) begin
      // mask set only between services, never nested
      @(posedge sys_clk_i);
      {irq, mask_set_i} <= {4'hf >> (3 - i), 1'h1};
      @(posedge sys_clk_i);
      mask_set_i <= 1'h0;
      wait_for(1'h1);
      chk(irq_ack_o, 12'h001 << i);
      @(posedge sys_clk_i);
      irq <= 4'h0;
      wait_for(1'h0);
      chk(pc_o, vec[i]);
      chk(condition_flags_o[4], 12'h000);
      @(posedge sys_clk_i);
      interrupt_return_i <= 1'h1;
      @(posedge sys_clk_i);
      interrupt_return_i <= 1'h0;
      wait_for(1'h0);
      chk({condition_flags_o[4], pc_o[10:0]}, 12'h8a3);
    end
  endtask
  task automatic s_rerun;
    logic [8:0] d;
    mem_wr(8'hce, 8'h05);
    @(posedge sys_clk_i);
    {sys_rst_i, normal_mode_i} <= {1'h1, 1'h0};
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'h0;
    #1 chk(pc_o, 12'h840);
    chk(condition_flags_o, 12'h000);
    mem_rd(8'hce, d);
    chk(d, 12'h10f);
    chk(pc_o, 12'h840);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk_i);
    sys_rst_i <= 1'h0;
    #1 s_reset();
    s_flags();
    s_index();
    s_call();
    s_irq();
    s_rerun();
    final_report();
  end
endmodule
